// file: include/fcpc_pkg.sv
// Constants and types shared by the flash command and protection controller.
package fcpc_pkg;

  // Control register offsets on the register port.
  localparam logic [15:0] FCPC_OFS_CLKDIV = 16'h1820;
  localparam logic [15:0] FCPC_OFS_OPT = 16'h1821;
  localparam logic [15:0] FCPC_OFS_PROT = 16'h1824;
  localparam logic [15:0] FCPC_OFS_STAT = 16'h1825;
  localparam logic [15:0] FCPC_OFS_CMD = 16'h1826;

  // Nonvolatile configuration words inside the array.
  localparam logic [15:0] FCPC_OFS_NV_PROT = 16'hFFBD;
  localparam logic [15:0] FCPC_OFS_NV_OPT = 16'hFFBF;

  // Default start of the flash array and top of flash.
  localparam logic [15:0] FCPC_FLASH_BASE = 16'hF000;
  localparam logic [15:0] FCPC_FLASH_TOP = 16'hFFFF;

  // Command codes.
  localparam logic [7:0] FCPC_CMD_BLANK = 8'h05;
  localparam logic [7:0] FCPC_CMD_PROG = 8'h20;
  localparam logic [7:0] FCPC_CMD_BURST = 8'h25;
  localparam logic [7:0] FCPC_CMD_PAGE = 8'h40;
  localparam logic [7:0] FCPC_CMD_MASS = 8'h41;

  // Status register bit positions.
  localparam int FCPC_ST_CBEF = 7;
  localparam int FCPC_ST_CCF = 6;
  localparam int FCPC_ST_PVIOL = 5;
  localparam int FCPC_ST_ACCERR = 4;

  // Divider, protection and option bit positions.
  localparam int FCPC_DIV_LOADED = 7;
  localparam int FCPC_DIV_PRE8 = 6;
  localparam int FCPC_PROT_DIS = 0;
  localparam int FCPC_OPT_REDIR_DIS = 6;

  // Page and row geometry as address bit counts.
  localparam int FCPC_PAGE_BITS = 9;
  localparam int FCPC_ROW_BITS = 6;

  // Interrupt vector window, reset vector excluded.
  localparam logic [15:0] FCPC_VEC_LO = 16'hFFC0;
  localparam logic [15:0] FCPC_VEC_HI = 16'hFFFD;

  // Command durations in flash timing clock periods.
  localparam int FCPC_CNT_W = 15;
  localparam logic [14:0] FCPC_FCLK_BYTE = 15'd9;
  localparam logic [14:0] FCPC_FCLK_BURST = 15'd4;
  localparam logic [14:0] FCPC_FCLK_PAGE = 15'd4000;
  localparam logic [14:0] FCPC_FCLK_MASS = 15'd20000;
  localparam logic [14:0] FCPC_FCLK_BLANK = 15'd2;

  // Values after reset.
  localparam logic [7:0] FCPC_CLKDIV_RST = 8'h00;
  localparam logic [7:0] FCPC_NV_RST = 8'hFF;
  localparam logic [7:0] FCPC_BYTE_RST = 8'h00;
  localparam logic [15:0] FCPC_ADDR_RST = 16'h0000;

  typedef enum logic [1:0] {
    FCPC_SEQ_IDLE = 2'b00,
    FCPC_SEQ_ADDR = 2'b01,
    FCPC_SEQ_CMD = 2'b10,
    FCPC_SEQ_QUEUED = 2'b11
  } fcpc_seq_t;

  typedef enum logic {
    FCPC_EX_IDLE = 1'b0,
    FCPC_EX_RUN = 1'b1
  } fcpc_ex_t;

endpackage : fcpc_pkg

// file: hw/fcpc_timer.sv
// Flash timing clock divider and command duration counter.
`timescale 1ns/1ps
module fcpc_timer #(
  parameter int CNT_W = 15
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Divider setting.
  input wire logic [5:0] div_i,
  input wire logic pre8_i,
  // Run control.
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [CNT_W-1:0] cycles_i,
  output logic done_o
);
  import fcpc_pkg::*;

  logic [2:0] pre_reg, pre_next;
  logic [5:0] div_reg, div_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic run_reg, run_next;
  logic pre_tick;
  logic fclk_tick;

  // One timing clock period is (div+1) bus cycles, times eight with pre8.
  always_comb begin
    pre_next = pre_reg;
    div_next = div_reg;
    cnt_next = cnt_reg;
    run_next = run_reg;
    pre_tick = !pre8_i || (pre_reg == 3'h7);
    fclk_tick = pre_tick && (div_reg == div_i);
    // Done depends only on state and the divider setting, not on start, so a
    // restart in the same cycle cannot feed back into it.
    done_o = run_reg && fclk_tick && (cnt_reg <= CNT_W'(1));
    if (start_i) begin
      pre_next = 3'h0;
      div_next = 6'h00;
      cnt_next = cycles_i;
      run_next = 1'b1;
    end else if (abort_i) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      pre_next = pre_tick ? 3'h0 : pre_reg + 3'h1;
      if (pre_tick) begin
        div_next = fclk_tick ? 6'h00 : div_reg + 6'h01;
      end
      if (fclk_tick) begin
        if (done_o) begin
          run_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_reg <= 3'h0;
      div_reg <= 6'h00;
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      run_reg <= run_next;
    end
  end

endmodule : fcpc_timer

// file: hw/fcpc_ctrl.sv
// Flash command sequencer with access checks, block protection and redirect.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Sequence opens with one array write, latched.
// - Page erase hits whole page; mass anywhere.
// - Codes 05, 40, 41 recognised and buffered.
// - Codes 20 and 25 recognised.
// - Writing one to buffer flag launches.
// - Writing zero there aborts and flags error.
// - Complete flag shows all commands finished.
// - Pump held only for queued same-row burst.
// - Row start byte takes standard program time.
// - First burst byte standard, later bytes short.
// - Error flag cleared by one; blocks commands.
// - Array write before divider write is error.
// - Array write with buffer full is error.
// - Second array or command write is error.
// - Stray control writes mid-sequence are errors.
// - Unknown command code is error.
// - Stop mode aborts program/erase with error.
// - Secured debug may only blank/mass erase.
// - Protected region above last unprotected address.
// - Protection active when disable bit zero.
// - Protection loaded at reset; debug-only writes.
// - Vectors redirected below boundary; reset never.
// - Divider-loaded bit gates program and erase.
module fcpc_ctrl #(
  parameter logic [15:0] FLASH_BASE = fcpc_pkg::FCPC_FLASH_BASE,
  parameter logic [14:0] PAGE_FCLK = fcpc_pkg::FCPC_FCLK_PAGE,
  parameter logic [14:0] MASS_FCLK = fcpc_pkg::FCPC_FCLK_MASS
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register and array write port.
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // System state.
  input wire logic bdm_i,
  input wire logic secure_i,
  input wire logic stop_i,
  // Nonvolatile configuration words.
  input wire logic [7:0] prot_nv_i,
  input wire logic [7:0] opt_nv_i,
  // Array control.
  output logic [15:0] array_addr_o,
  output logic [7:0] array_data_o,
  output logic [7:0] op_code_o,
  output logic op_busy_o,
  output logic pump_en_o,
  // Vector fetch redirection.
  input wire logic [15:0] vec_addr_i,
  output logic [15:0] vec_addr_o
);
  import fcpc_pkg::*;

  fcpc_seq_t seq_reg, seq_next;
  fcpc_ex_t ex_reg, ex_next;
  logic [15:0] baddr_reg, baddr_next;
  logic [7:0] bdata_reg, bdata_next;
  logic [7:0] bcmd_reg, bcmd_next;
  logic [15:0] caddr_reg, caddr_next;
  logic [7:0] cdata_reg, cdata_next;
  logic [7:0] ccmd_reg, ccmd_next;
  logic pump_reg, pump_next;
  logic accerr_reg, accerr_next;
  logic pviol_reg, pviol_next;
  logic [7:0] div_reg, div_next;
  logic [7:0] prot_reg, prot_next;
  logic [7:0] opt_reg, opt_next;
  logic load_reg, load_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [15:0] vec_reg, vec_next;
  logic acc_set;
  logic pv_set;
  logic t_start;
  logic t_abort;
  logic [14:0] t_cycles;
  logic t_done;
  logic cbef;
  logic ccf;
  logic mid_seq;
  logic [15:0] last_open;

  // Address falls inside the flash array.
  function automatic logic is_array(input logic [15:0] a);
    is_array = (a >= FLASH_BASE);
  endfunction : is_array

  // Address is one of the flash control registers.
  function automatic logic is_ctrl(input logic [15:0] a);
    is_ctrl = (a == FCPC_OFS_CLKDIV) || (a == FCPC_OFS_OPT) ||
              (a == FCPC_OFS_PROT) || (a == FCPC_OFS_STAT) ||
              (a == FCPC_OFS_CMD);
  endfunction : is_ctrl

  // Code is one of the five accepted commands.
  function automatic logic is_valid(input logic [7:0] c);
    is_valid = (c == FCPC_CMD_BLANK) || (c == FCPC_CMD_PROG) ||
               (c == FCPC_CMD_BURST) || (c == FCPC_CMD_PAGE) ||
               (c == FCPC_CMD_MASS);
  endfunction : is_valid

  // Standard duration of a command in timing clock periods.
  function automatic logic [14:0] std_time(input logic [7:0] c);
    case (c)
      FCPC_CMD_PAGE: std_time = PAGE_FCLK;
      FCPC_CMD_MASS: std_time = MASS_FCLK;
      FCPC_CMD_BLANK: std_time = FCPC_FCLK_BLANK;
      default: std_time = FCPC_FCLK_BYTE;
    endcase
  endfunction : std_time

  // Protection only counts when the disable bit is clear.
  assign last_open = {prot_reg[7:1], {FCPC_PAGE_BITS{1'b1}}};

  function automatic logic blocked(input logic [7:0] c,
                                   input logic [15:0] a,
                                   input logic [7:0] p,
                                   input logic [15:0] lo);
    logic active;
    active = !p[FCPC_PROT_DIS];
    if (c == FCPC_CMD_BLANK) begin
      blocked = 1'b0;
    end else if (c == FCPC_CMD_MASS) begin
      blocked = active && (lo != FCPC_FLASH_TOP);
    end else begin
      blocked = active && (a > lo);
    end
  endfunction : blocked

  assign mid_seq = (seq_reg == FCPC_SEQ_ADDR) || (seq_reg == FCPC_SEQ_CMD);
  assign cbef = (seq_reg != FCPC_SEQ_QUEUED);
  assign ccf = cbef && (ex_reg == FCPC_EX_IDLE);

  fcpc_timer #(
    .CNT_W(FCPC_CNT_W)
  ) u_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .div_i(div_reg[5:0]),
    .pre8_i(div_reg[FCPC_DIV_PRE8]),
    .start_i(t_start),
    .abort_i(t_abort),
    .cycles_i(t_cycles),
    .done_o(t_done)
  );

  always_comb begin
    seq_next = seq_reg;
    ex_next = ex_reg;
    baddr_next = baddr_reg;
    bdata_next = bdata_reg;
    bcmd_next = bcmd_reg;
    caddr_next = caddr_reg;
    cdata_next = cdata_reg;
    ccmd_next = ccmd_reg;
    pump_next = pump_reg;
    div_next = div_reg;
    prot_next = prot_reg;
    opt_next = opt_reg;
    load_next = 1'b0;
    acc_set = 1'b0;
    pv_set = 1'b0;
    t_start = 1'b0;
    t_abort = 1'b0;
    t_cycles = FCPC_FCLK_BYTE;

    // Command sequence driven by bus writes.
    if (wr_i) begin
      if (is_array(addr_i)) begin
        if (!div_reg[FCPC_DIV_LOADED]) begin
          acc_set = 1'b1;
        end else if (!accerr_reg) begin
          case (seq_reg)
            FCPC_SEQ_IDLE: begin
              baddr_next = addr_i;
              bdata_next = wdata_i;
              seq_next = FCPC_SEQ_ADDR;
            end
            FCPC_SEQ_QUEUED: acc_set = 1'b1;
            default: acc_set = 1'b1;
          endcase
        end
      end else if (addr_i == FCPC_OFS_CMD) begin
        if (!accerr_reg) begin
          case (seq_reg)
            FCPC_SEQ_ADDR: begin
              if (!is_valid(wdata_i)) begin
                acc_set = 1'b1;
              end else if (bdm_i && secure_i &&
                           (wdata_i != FCPC_CMD_BLANK) &&
                           (wdata_i != FCPC_CMD_MASS)) begin
                acc_set = 1'b1;
              end else begin
                bcmd_next = wdata_i;
                seq_next = FCPC_SEQ_CMD;
              end
            end
            FCPC_SEQ_CMD: acc_set = 1'b1;
            default: ;
          endcase
        end
      end else if (addr_i == FCPC_OFS_STAT) begin
        if (seq_reg == FCPC_SEQ_CMD && wdata_i[FCPC_ST_CBEF]) begin
          seq_next = FCPC_SEQ_QUEUED;
        end else if (mid_seq) begin
          acc_set = 1'b1;
        end
      end else if (is_ctrl(addr_i) && mid_seq) begin
        acc_set = 1'b1;
      end else if (!mid_seq) begin
        if (addr_i == FCPC_OFS_CLKDIV && !accerr_reg &&
            !div_reg[FCPC_DIV_LOADED]) begin
          div_next = {1'b1, wdata_i[6:0]};
        end
        if (addr_i == FCPC_OFS_PROT && bdm_i) begin
          prot_next = wdata_i;
        end
      end
      if (acc_set && mid_seq) begin
        seq_next = FCPC_SEQ_IDLE;
      end
    end

    // Working configuration is copied from the array after reset release.
    if (load_reg) begin
      prot_next = prot_nv_i;
      opt_next = opt_nv_i;
    end

    // Execution of the buffered command.
    case (ex_reg)
      FCPC_EX_IDLE: begin
        if (seq_reg == FCPC_SEQ_QUEUED) begin
          seq_next = FCPC_SEQ_IDLE;
          if (blocked(bcmd_reg, baddr_reg, prot_reg, last_open)) begin
            pv_set = 1'b1;
          end else begin
            caddr_next = baddr_reg;
            cdata_next = bdata_reg;
            ccmd_next = bcmd_reg;
            ex_next = FCPC_EX_RUN;
            pump_next = (bcmd_reg != FCPC_CMD_BLANK);
            t_start = 1'b1;
            t_cycles = std_time(bcmd_reg);
          end
        end
      end
      FCPC_EX_RUN: begin
        if (stop_i && ccmd_reg != FCPC_CMD_BLANK) begin
          acc_set = 1'b1;
          t_abort = 1'b1;
          ex_next = FCPC_EX_IDLE;
          pump_next = 1'b0;
        end else if (t_done) begin
          if (seq_reg == FCPC_SEQ_QUEUED &&
              ccmd_reg == FCPC_CMD_BURST && bcmd_reg == FCPC_CMD_BURST &&
              baddr_reg[15:FCPC_ROW_BITS] == caddr_reg[15:FCPC_ROW_BITS] &&
              baddr_reg[FCPC_ROW_BITS-1:0] != '0 &&
              !blocked(bcmd_reg, baddr_reg, prot_reg, last_open)) begin
            seq_next = FCPC_SEQ_IDLE;
            caddr_next = baddr_reg;
            cdata_next = bdata_reg;
            t_start = 1'b1;
            t_cycles = FCPC_FCLK_BURST;
          end else begin
            ex_next = FCPC_EX_IDLE;
            pump_next = 1'b0;
          end
        end
      end
      default: ex_next = FCPC_EX_IDLE;
    endcase
  end

  // Flags: a hardware set wins over a write-one clear in the same cycle.
  always_comb begin
    accerr_next = acc_set || (accerr_reg && !(wr_i &&
                  addr_i == FCPC_OFS_STAT && wdata_i[FCPC_ST_ACCERR]));
    pviol_next = pv_set || (pviol_reg && !(wr_i &&
                 addr_i == FCPC_OFS_STAT && wdata_i[FCPC_ST_PVIOL]));
  end

  // Read data appear in the cycle after the read strobe only.
  always_comb begin
    rdata_next = FCPC_BYTE_RST;
    if (rd_i) begin
      case (addr_i)
        FCPC_OFS_CLKDIV: rdata_next = div_reg;
        FCPC_OFS_OPT: rdata_next = opt_reg;
        FCPC_OFS_PROT: rdata_next = prot_reg;
        FCPC_OFS_STAT: rdata_next = {cbef, ccf, pviol_reg, accerr_reg,
                                     4'h0};
        FCPC_OFS_CMD: rdata_next = bcmd_reg;
        default: rdata_next = FCPC_BYTE_RST;
      endcase
    end
  end

  // Interrupt vectors move below the protected boundary; reset does not.
  always_comb begin
    vec_next = vec_addr_i;
    if (!opt_reg[FCPC_OPT_REDIR_DIS] && !prot_reg[FCPC_PROT_DIS] &&
        last_open != FCPC_FLASH_TOP && last_open >= FLASH_BASE &&
        vec_addr_i >= FCPC_VEC_LO && vec_addr_i <= FCPC_VEC_HI) begin
      vec_next = {last_open[15:FCPC_PAGE_BITS],
                  vec_addr_i[FCPC_PAGE_BITS-1:0]};
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seq_reg <= FCPC_SEQ_IDLE;
      ex_reg <= FCPC_EX_IDLE;
      baddr_reg <= FCPC_ADDR_RST;
      bdata_reg <= FCPC_BYTE_RST;
      bcmd_reg <= FCPC_BYTE_RST;
      caddr_reg <= FCPC_ADDR_RST;
      cdata_reg <= FCPC_BYTE_RST;
      ccmd_reg <= FCPC_BYTE_RST;
      pump_reg <= 1'b0;
      accerr_reg <= 1'b0;
      pviol_reg <= 1'b0;
      div_reg <= FCPC_CLKDIV_RST;
      prot_reg <= FCPC_NV_RST;
      opt_reg <= FCPC_NV_RST;
      load_reg <= 1'b1;
      rdata_reg <= FCPC_BYTE_RST;
      vec_reg <= FCPC_ADDR_RST;
    end else begin
      seq_reg <= seq_next;
      ex_reg <= ex_next;
      baddr_reg <= baddr_next;
      bdata_reg <= bdata_next;
      bcmd_reg <= bcmd_next;
      caddr_reg <= caddr_next;
      cdata_reg <= cdata_next;
      ccmd_reg <= ccmd_next;
      pump_reg <= pump_next;
      accerr_reg <= accerr_next;
      pviol_reg <= pviol_next;
      div_reg <= div_next;
      prot_reg <= prot_next;
      opt_reg <= opt_next;
      load_reg <= load_next;
      rdata_reg <= rdata_next;
      vec_reg <= vec_next;
    end
  end

  // Page erase targets the page base so the whole page is cleared.
  assign array_addr_o = (ccmd_reg == FCPC_CMD_PAGE) ?
      {caddr_reg[15:FCPC_PAGE_BITS], {FCPC_PAGE_BITS{1'b0}}} :
      caddr_reg;
  assign array_data_o = cdata_reg;
  assign op_code_o = ccmd_reg;
  assign op_busy_o = (ex_reg == FCPC_EX_RUN);
  assign pump_en_o = pump_reg;
  assign rdata_o = rdata_reg;
  assign vec_addr_o = vec_reg;

endmodule : fcpc_ctrl

// file: tb/fcpc_ctrl_asserts.sv
// Port-level assertions for the flash command controller.
`timescale 1ns/1ps
module fcpc_ctrl_asserts
  import fcpc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port.
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // System state.
  input wire logic stop_i,
  // Array control.
  input wire logic [15:0] array_addr_o,
  input wire logic [7:0] op_code_o,
  input wire logic op_busy_o,
  input wire logic pump_en_o,
  // Vector fetch.
  input wire logic [15:0] vec_addr_i,
  input wire logic [15:0] vec_addr_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_stat_ccf: assert property (rd_i && addr_i == FCPC_OFS_STAT && op_busy_o
    |=> !rdata_o[FCPC_ST_CCF]) else $error("complete flag while busy");
  a_stat_pad: assert property (rd_i && addr_i == FCPC_OFS_STAT
    |=> rdata_o[3:0] == 4'h0) else $error("status low bits set");
  a_pump_idle: assert property (!op_busy_o && !$past(op_busy_o)
    |-> !pump_en_o) else $error("pump on while idle");
  a_blank_nopump: assert property (op_busy_o && op_code_o == FCPC_CMD_BLANK
    |-> !pump_en_o) else $error("pump on for blank check");
  a_page_base: assert property (op_busy_o && op_code_o == FCPC_CMD_PAGE
    |-> array_addr_o[8:0] == 9'h000) else $error("page not aligned");
  a_code_valid: assert property (op_busy_o |-> op_code_o inside
    {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("bad code ran");
  a_code_stable: assert property (op_busy_o && $past(op_busy_o)
    |-> $stable(op_code_o)) else $error("code changed in run");
  a_stop_abort: assert property (stop_i && op_busy_o &&
    op_code_o != FCPC_CMD_BLANK |-> ##[1:3] !op_busy_o)
    else $error("stop did not abort");
  a_vec_pass: assert property (!(vec_addr_i inside {[16'hFFC0:16'hFFFD]})
    |=> vec_addr_o == $past(vec_addr_i)) else $error("vector moved");
  a_vec_offset: assert property (vec_addr_i inside {[16'hFFC0:16'hFFFD]}
    |=> vec_addr_o[8:0] == $past(vec_addr_i[8:0]))
    else $error("vector offset lost");

  cover property ($rose(op_busy_o) && op_code_o == FCPC_CMD_BURST);
  cover property (stop_i && op_busy_o);
  cover property (vec_addr_o inside {[16'hFDC0:16'hFDFD]});
endmodule : fcpc_ctrl_asserts

bind fcpc_ctrl fcpc_ctrl_asserts chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_i(stop_i),
  .array_addr_o(array_addr_o), .op_code_o(op_code_o),
  .op_busy_o(op_busy_o), .pump_en_o(pump_en_o),
  .vec_addr_i(vec_addr_i), .vec_addr_o(vec_addr_o));

// file: tb/fcpc_host_mdl.sv
// Bus master model standing in for the processor on the register port.
`timescale 1ns/1ps
module fcpc_host_mdl (
  // Clock.
  input wire logic clk_i,
  // Register port.
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Strobes stay high between back-to-back writes; idle drops them.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    rd_o <= 1'b0;
    wr_o <= 1'b1;
    @(posedge clk_i);
  endtask : wr

  task automatic idle(input int n);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : idle

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    addr_o <= a;
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd

  // Array write, command code, then launch through the buffer flag.
  task automatic cmd_seq(input logic [15:0] a, input logic [7:0] d,
                         input logic [7:0] c);
    wr(a, d);
    wr(fcpc_pkg::FCPC_OFS_CMD, c);
    wr(fcpc_pkg::FCPC_OFS_STAT, 8'h80);
    idle(1);
  endtask : cmd_seq
endmodule : fcpc_host_mdl

// file: tb/tb_top.sv
// Self-checking bench for the flash command controller.
`timescale 1ns/1ps
module tb_top;
  import fcpc_pkg::*;
  localparam logic [15:0] AR = 16'hF234;
  localparam logic [15:0] ST = FCPC_OFS_STAT;
  localparam logic [15:0] CM = FCPC_OFS_CMD;
  localparam logic [15:0] DV = FCPC_OFS_CLKDIV;
  logic clk_i, arst_n_i, wr_i, rd_i, bdm_i, secure_i, stop_i;
  logic [15:0] addr_i, vec_addr_i, array_addr_o, vec_addr_o, aa;
  logic [7:0] wdata_i, rdata_o, prot_nv_i, opt_nv_i, array_data_o;
  logic [7:0] op_code_o, d, oc, ad;
  logic op_busy_o, pump_en_o, pm;
  int errors, n_checks, len, pl, i;
  logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
  logic [15:0] lens [5] = '{16'h2, 16'h9, 16'h9, 16'h5, 16'h8};
  logic [7:0] sec_st [5] = '{8'hC0, 8'hD0, 8'hD0, 8'hD0, 8'hC0};
  logic [23:0] bad [7][3] = '{
    '{{AR, 8'h00}, {CM, 8'h33}, 24'h0},
    '{{AR, 8'h00}, {AR, 8'h00}, 24'h0},
    '{{AR, 8'h00}, {CM, 8'h20}, {CM, 8'h20}},
    '{{AR, 8'h00}, {DV, 8'h00}, 24'h0},
    '{{AR, 8'h00}, {CM, 8'h20}, {FCPC_OFS_OPT, 8'h00}},
    '{{AR, 8'h00}, {ST, 8'h00}, 24'h0},
    '{{AR, 8'h00}, {CM, 8'h20}, {ST, 8'h00}}};

  fcpc_host_mdl host_u (.clk_i(clk_i), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .rdata_i(rdata_o));

  fcpc_ctrl #(.PAGE_FCLK(15'h0005), .MASS_FCLK(15'h0008)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bdm_i(bdm_i), .secure_i(secure_i), .stop_i(stop_i),
    .prot_nv_i(prot_nv_i), .opt_nv_i(opt_nv_i),
    .array_addr_o(array_addr_o), .array_data_o(array_data_o),
    .op_code_o(op_code_o), .op_busy_o(op_busy_o), .pump_en_o(pump_en_o),
    .vec_addr_i(vec_addr_i), .vec_addr_o(vec_addr_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic rd_stat(input logic [7:0] exp);
    host_u.rd(ST, d);
    chk("status", 16'(d), 16'(exp));
  endtask : rd_stat

  task automatic clr();
    host_u.wr(ST, 8'h30);
    host_u.idle(1);
  endtask : clr

  // Runs one command and records what the array side saw first.
  task automatic launch(input logic [15:0] a, input logic [7:0] c);
    int k;
    len = 0;
    host_u.cmd_seq(a, 8'h5A, c);
    for (k = 0; k < 8 && op_busy_o !== 1'b1; k++) @(posedge clk_i);
    aa = array_addr_o;
    oc = op_code_o;
    pm = pump_en_o;
    ad = array_data_o;
    for (k = 0; k < 99 && op_busy_o === 1'b1; k++) begin
      len++;
      @(posedge clk_i);
    end
    if (k == 99) begin
      errors++;
      tally_and_finish();
    end
  endtask : launch

  // Waits until busy and pump have both stayed low for three cycles.
  task automatic drain();
    int k, q;
    q = 0;
    for (k = 0; k < 99 && q < 3; k++) begin
      q = (op_busy_o === 1'b1 || pump_en_o === 1'b1) ? 0 : q + 1;
      @(posedge clk_i);
    end
    if (k == 99) begin
      errors++;
      tally_and_finish();
    end
  endtask : drain

  // Two burst bytes, the second queued while the first runs.
  task automatic burst(input logic [15:0] a);
    int k;
    host_u.cmd_seq(a, 8'h11, FCPC_CMD_BURST);
    pl = 0;
    fork
      begin
        host_u.idle(2);
        host_u.cmd_seq(a + 16'h0001, 8'h22, FCPC_CMD_BURST);
        rd_stat(8'h00);
      end
      begin
        for (k = 0; k < 8 && pump_en_o !== 1'b1; k++) @(posedge clk_i);
        for (k = 0; k < 40 && pump_en_o === 1'b1; k++) begin
          pl++;
          @(posedge clk_i);
        end
      end
    join
    drain();
  endtask : burst

  task automatic do_reset(input logic [7:0] p, o);
    arst_n_i <= 1'b0;
    prot_nv_i <= p;
    opt_nv_i <= o;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask : do_reset

  initial begin
    errors = 0;
    n_checks = 0;
    arst_n_i = 1'b0;
    bdm_i = 1'b0;
    secure_i = 1'b0;
    stop_i = 1'b0;
    vec_addr_i = 16'h0000;
    @(posedge clk_i);
    do_reset(8'hFF, 8'hFF);
    host_u.rd(DV, d);
    chk("divider", 16'(d), 16'h0000);
    launch(AR, FCPC_CMD_PROG);
    chk("early run", 16'(len), 16'h0);
    rd_stat(8'hD0);
    launch(AR, FCPC_CMD_PROG);
    chk("blocked run", 16'(len), 16'h0);
    clr();
    rd_stat(8'hC0);
    host_u.wr(DV, 8'h00);
    host_u.wr(DV, 8'h05);
    host_u.rd(DV, d);
    chk("divider", 16'(d), 16'h0080);
    for (i = 0; i < 5; i++) begin
      launch(AR, codes[i]);
      chk("length", 16'(len), lens[i]);
      chk("code", 16'(oc), 16'(codes[i]));
      chk("target", aa, i == 3 ? 16'hF200 : AR);
      chk("pump", 16'(pm), 16'(i != 0));
      if (i == 1) chk("data", 16'(ad), 16'h005A);
      rd_stat(8'hC0);
    end
    for (i = 0; i < 7; i++) begin
      for (int j = 0; j < 3; j++) begin
        if (bad[i][j] != 24'h0) host_u.wr(bad[i][j][23:8], bad[i][j][7:0]);
      end
      host_u.idle(1);
      rd_stat(8'hD0);
      launch(AR, FCPC_CMD_PROG);
      chk("blocked run", 16'(len), 16'h0);
      clr();
    end
    host_u.cmd_seq(AR, 8'h00, FCPC_CMD_PAGE);
    for (i = 0; i < 8 && op_busy_o !== 1'b1; i++) @(posedge clk_i);
    stop_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    drain();
    rd_stat(8'hD0);
    clr();
    host_u.cmd_seq(16'hF000, 8'h01, FCPC_CMD_PROG);
    host_u.idle(2);
    host_u.cmd_seq(16'hF001, 8'h02, FCPC_CMD_PROG);
    host_u.wr(AR, 8'h03);
    host_u.idle(1);
    drain();
    rd_stat(8'hD0);
    clr();
    bdm_i <= 1'b1;
    secure_i <= 1'b1;
    for (i = 0; i < 5; i++) begin
      launch(AR, codes[i]);
      chk("secured", 16'(len), sec_st[i] == 8'hC0 ? lens[i] : 16'h0);
      rd_stat(sec_st[i]);
      clr();
    end
    bdm_i <= 1'b0;
    secure_i <= 1'b0;
    burst(16'hF030);
    chk("pump held", 16'(pl), 16'h000D);
    burst(16'hF03F);
    chk("row start", 16'(pl), 16'h0009);
    do_reset(8'hFC, 8'hBF);
    host_u.wr(DV, 8'h00);
    host_u.wr(FCPC_OFS_PROT, 8'hFF);
    host_u.rd(FCPC_OFS_PROT, d);
    chk("protect", 16'(d), 16'h00FC);
    launch(16'hFE10, FCPC_CMD_PROG);
    chk("guarded", 16'(len), 16'h0);
    rd_stat(8'hE0);
    clr();
    launch(16'hFDFF, FCPC_CMD_PROG);
    chk("open", 16'(len), 16'h9);
    vec_addr_i <= 16'hFFE0;
    repeat (2) @(posedge clk_i);
    chk("vector", vec_addr_o, 16'hFDE0);
    vec_addr_i <= 16'hFFFE;
    repeat (2) @(posedge clk_i);
    chk("reset vector", vec_addr_o, 16'hFFFE);
    bdm_i <= 1'b1;
    host_u.wr(FCPC_OFS_PROT, 8'hFF);
    host_u.idle(1);
    bdm_i <= 1'b0;
    launch(16'hFE10, FCPC_CMD_PROG);
    chk("unguarded", 16'(len), 16'h9);
    tally_and_finish();
  end
endmodule : tb_top
